// ### design/rfid_cmd_pkg.sv
// Constants and types for the command bit decoder.
// Assumes a single 25 MHz clock domain with asynchronous active-low reset.
package rfid_cmd_pkg;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned CMD_COUNT       = 5;
    localparam int unsigned BYTE_COUNT_W    = 3;
    localparam int unsigned ADDR_W          = 16;
    localparam int unsigned INFO_BYTES      = 8;
    localparam int unsigned ERR_CODE_W      = 16;
    // Command bit positions in the command vector
    localparam int unsigned CMD_TAG_IDENTIFIER_CMD      = 0;
    localparam int unsigned CMD_READ        = 1;
    localparam int unsigned CMD_WRITE       = 2;
    localparam int unsigned CMD_TAG_INFORMATION_CMD    = 3;
    localparam int unsigned CMD_HEAD_INFO   = 4;
    // Reset values and error codes
    localparam logic [4:0]  CMD_RESET_VAL   = 5'h00;
    localparam logic [15:0] ERR_CODE_NONE   = 16'h0000;
    localparam logic [15:0] ERR_CODE_MULTI  = 16'h0001;
    localparam logic [15:0] ERR_CODE_ABORT  = 16'h0002;
    // Tag information filler bytes
    localparam logic [7:0]  INFO_UNSUPPORTED = 8'h00;
    localparam logic [7:0]  INFO_ZERO        = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_TAG_IDENTIFIER_CMD,
        OP_READ,
        OP_WRITE,
        OP_TAG_INFORMATION_CMD,
        OP_HEAD_INFO
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PENDING,
        ST_RUN,
        ST_LOCKED
    } state_t;
endpackage

// ### design/rfid_sync2.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the level changes slower than the clock.
`timescale 1ns/1ns
module rfid_sync2 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    always_comb begin
        next_stage1 = async_in;
        next_stage2 = stage1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_out = stage2;
endmodule

// ### design/rfid_command_bit_decoder.sv
// Decoder of the command and control bits of the cyclic output image.
// Assumes a new image is flagged by image_valid on clk; tag present/changed and engine
// done/error from the head side are asynchronous and are synchronised here.
`timescale 1ns/1ns
module rfid_command_bit_decoder
    import rfid_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    // Process output image
    input  wire logic                                 image_valid,
    input  wire logic                                 head_enable,
    input  wire logic                                 single_cmd_per_tag,
    input  wire logic                                 tag_identifier_cmd,
    input  wire logic                                 read_cmd,
    input  wire logic                                 write_cmd,
    input  wire logic                                 tag_information_cmd,
    input  wire logic                                 head_information_cmd,
    input  wire logic                                 reset_cmd,
    input  wire logic [rfid_cmd_pkg::BYTE_COUNT_W-1:0] byte_count_field,
    input  wire logic [7:0]                           tag_address_high,
    input  wire logic [7:0]                           tag_address_low,
    // Head side status
    input  wire logic                                 tag_present,
    input  wire logic                                 tag_changed,
    input  wire logic                                 engine_done,
    input  wire logic                                 engine_error,
    input  wire logic [7:0]                           tag_block_count,
    input  wire logic [7:0]                           tag_block_size,
    // Head and engine control
    output logic                                      head_on,
    output logic                                      op_start,
    output rfid_cmd_pkg::op_t                         op_kind,
    output logic [rfid_cmd_pkg::ADDR_W-1:0]           op_address,
    output logic [3:0]                                op_length,
    output logic                                      op_abort,
    // Process input status
    output logic                                      busy,
    output logic                                      done,
    output logic                                      error,
    output logic [rfid_cmd_pkg::ERR_CODE_W-1:0]       error_code,
    output logic                                      info_valid,
    output logic [63:0]                               info_data
);
    logic tp_s;
    logic tc_s;
    logic ed_s;
    logic ee_s;

    rfid_sync2 u_sync_tp (.clk(clk), .reset_n(reset_n), .async_in(tag_present),  .sync_out(tp_s));
    rfid_sync2 u_sync_tc (.clk(clk), .reset_n(reset_n), .async_in(tag_changed),  .sync_out(tc_s));
    rfid_sync2 u_sync_ed (.clk(clk), .reset_n(reset_n), .async_in(engine_done),  .sync_out(ed_s));
    rfid_sync2 u_sync_ee (.clk(clk), .reset_n(reset_n), .async_in(engine_error), .sync_out(ee_s));

    logic [CMD_COUNT-1:0] cmd_now;
    logic [CMD_COUNT-1:0] cmd_prev;
    logic                 reset_prev;
    logic                 tc_prev;
    logic [CMD_COUNT-1:0] rise;
    logic                 reset_rise;
    logic                 multi;
    state_t               state;
    op_t                  pend_op;
    logic                 used;
    logic                 ed_prev;
    logic                 done_rise;

    logic [CMD_COUNT-1:0] next_cmd_prev;
    logic                 next_reset_prev;
    logic                 next_tc_prev;
    logic                 next_ed_prev;
    state_t               next_state;
    op_t                  next_pend_op;
    logic                 next_used;
    logic                 next_head_on;
    logic                 next_op_start;
    op_t                  next_op_kind;
    logic [ADDR_W-1:0]    next_op_address;
    logic [3:0]           next_op_length;
    logic                 next_op_abort;
    logic                 next_done;
    logic                 next_error;
    logic [ERR_CODE_W-1:0] next_error_code;
    logic                 next_info_valid;
    logic [63:0]          next_info_data;

    assign cmd_now = {head_information_cmd, tag_information_cmd, write_cmd,
                      read_cmd, tag_identifier_cmd};
    assign rise       = image_valid ? (cmd_now & ~cmd_prev) : CMD_RESET_VAL;
    assign reset_rise = image_valid & reset_cmd & ~reset_prev;
    assign multi      = image_valid && ($countones(cmd_now) > 1) && (rise != CMD_RESET_VAL);
    assign done_rise  = ed_s & ~ed_prev;
    assign busy       = (state != ST_IDLE);

    always_comb begin
        next_cmd_prev   = image_valid ? cmd_now : cmd_prev;
        next_reset_prev = image_valid ? reset_cmd : reset_prev;
        next_tc_prev    = tc_s;
        next_ed_prev    = ed_s;
        next_state      = state;
        next_pend_op    = pend_op;
        next_used       = used;
        next_head_on    = head_on;
        next_op_start   = 1'b0;
        next_op_kind    = op_kind;
        next_op_address = op_address;
        next_op_length  = op_length;
        next_op_abort   = 1'b0;
        next_done       = done;
        next_error      = error;
        next_error_code = error_code;
        next_info_valid = info_valid;
        next_info_data  = info_data;

        if (tc_s && !tc_prev) begin
            next_used = 1'b0;
            if (state == ST_LOCKED) next_state = ST_IDLE;
        end

        unique case (state)
            ST_IDLE, ST_LOCKED: begin
                if (multi) begin
                    next_error      = 1'b1;
                    next_error_code = ERR_CODE_MULTI;
                end else if (rise != CMD_RESET_VAL && state == ST_IDLE) begin
                    next_done    = 1'b0;
                    next_info_valid = 1'b0;
                    next_op_address = {tag_address_high, tag_address_low};
                    next_op_length  = {1'b0, byte_count_field} + 4'h1;
                    if (rise[CMD_TAG_IDENTIFIER_CMD])        next_pend_op = OP_TAG_IDENTIFIER_CMD;
                    else if (rise[CMD_READ])     next_pend_op = OP_READ;
                    else if (rise[CMD_WRITE])    next_pend_op = OP_WRITE;
                    else if (rise[CMD_TAG_INFORMATION_CMD]) next_pend_op = OP_TAG_INFORMATION_CMD;
                    else                         next_pend_op = OP_HEAD_INFO;
                    if (single_cmd_per_tag && used) next_state = ST_LOCKED;
                    else                            next_state = ST_PENDING;
                end
            end
            ST_PENDING: begin
                if (tp_s || pend_op == OP_HEAD_INFO) begin
                    next_op_start = 1'b1;
                    next_op_kind  = pend_op;
                    next_state    = ST_RUN;
                end
            end
            ST_RUN: begin
                if (done_rise) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                    next_used  = 1'b1;
                    next_op_kind = OP_NONE;
                    if (ee_s) begin
                        next_error      = 1'b1;
                        next_error_code = ERR_CODE_ABORT;
                    end
                    if (op_kind == OP_TAG_INFORMATION_CMD && !ee_s) begin
                        next_info_valid = 1'b1;
                        next_info_data  = {INFO_ZERO, INFO_ZERO, INFO_ZERO,
                                           INFO_UNSUPPORTED, INFO_UNSUPPORTED,
                                           INFO_UNSUPPORTED,
                                           tag_block_size - 8'h01,
                                           tag_block_count - 8'h01};
                    end
                end
            end
        endcase

        // head follows enable, held while pending or running
        if (head_enable) next_head_on = 1'b1;
        else if (next_state == ST_IDLE || next_state == ST_LOCKED) next_head_on = 1'b0;

        if (reset_rise) begin
            next_op_abort   = (state == ST_RUN);
            next_op_start   = 1'b0;
            next_op_kind    = OP_NONE;
            next_state      = ST_IDLE;
            next_done       = 1'b1;
            next_used       = 1'b0;
            next_error      = 1'b0;
            next_error_code = ERR_CODE_NONE;
            next_head_on    = head_enable;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_prev   <= CMD_RESET_VAL;
            reset_prev <= 1'b0;
            tc_prev    <= 1'b0;
            ed_prev    <= 1'b0;
            state      <= ST_IDLE;
            pend_op    <= OP_NONE;
            used       <= 1'b0;
            head_on    <= 1'b0;
            op_start   <= 1'b0;
            op_kind    <= OP_NONE;
            op_address <= 16'h0000;
            op_length  <= 4'h0;
            op_abort   <= 1'b0;
            done       <= 1'b1;
            error      <= 1'b0;
            error_code <= ERR_CODE_NONE;
            info_valid <= 1'b0;
            info_data  <= 64'h0000000000000000;
        end else begin
            cmd_prev   <= next_cmd_prev;
            reset_prev <= next_reset_prev;
            tc_prev    <= next_tc_prev;
            ed_prev    <= next_ed_prev;
            state      <= next_state;
            pend_op    <= next_pend_op;
            used       <= next_used;
            head_on    <= next_head_on;
            op_start   <= next_op_start;
            op_kind    <= next_op_kind;
            op_address <= next_op_address;
            op_length  <= next_op_length;
            op_abort   <= next_op_abort;
            done       <= next_done;
            error      <= next_error;
            error_code <= next_error_code;
            info_valid <= next_info_valid;
            info_data  <= next_info_data;
        end
    end
endmodule

// ### verification/rfid_cmd_checker.sv
// Port checker for the command bit decoder.
// Assumes binding to the decoder top; one clock domain.
`timescale 1ns/1ns
module rfid_cmd_checker
    import rfid_cmd_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Output image
    input wire logic        image_valid,
    input wire logic        head_enable,
    input wire logic        tag_identifier_cmd,
    input wire logic        read_cmd,
    input wire logic        write_cmd,
    input wire logic        tag_information_cmd,
    input wire logic        head_information_cmd,
    input wire logic        reset_cmd,
    input wire logic [2:0]  byte_count_field,
    input wire logic [7:0]  tag_address_high,
    input wire logic [7:0]  tag_address_low,
    // Head side
    input wire logic        tag_present,
    input wire logic [7:0]  tag_block_count,
    input wire logic [7:0]  tag_block_size,
    // Outputs
    input wire logic        head_on,
    input wire logic        op_start,
    input rfid_cmd_pkg::op_t op_kind,
    input wire logic [15:0] op_address,
    input wire logic [3:0]  op_length,
    input wire logic        op_abort,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        error,
    input wire logic [15:0] error_code,
    input wire logic        info_valid,
    input wire logic [63:0] info_data
);
    logic [4:0] cmd;
    logic [4:0] prev;
    logic       prev_rst;
    assign cmd = {head_information_cmd, tag_information_cmd, write_cmd, read_cmd,
                  tag_identifier_cmd};
    // Previous image store
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev     <= 5'h00;
            prev_rst <= 1'b0;
        end else if (image_valid) begin
            prev     <= cmd;
            prev_rst <= reset_cmd;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_rise;
        image_valid && !busy && !(reset_cmd && !prev_rst) && (cmd & ~prev) != 5'h00;
    endsequence
    sequence s_reset;
        image_valid && reset_cmd && !prev_rst;
    endsequence
    property p_multi;
        s_rise ##0 ($countones(cmd) > 1) |=> error && error_code == 16'h0001;
    endproperty
    property p_accept;
        s_rise ##0 ($countones(cmd) == 1) |=> busy ##1 !done;
    endproperty
    property p_start;
        op_start |-> op_kind != OP_NONE ##1 !op_start;
    endproperty
    property p_abort;
        op_abort |=> !op_abort;
    endproperty
    property p_tag;
        op_start && op_kind != OP_HEAD_INFO |-> $past(tag_present, 2)
            || $past(tag_present, 3) || $past(tag_present, 4);
    endproperty
    property p_len;
        op_start && (op_kind == OP_READ || op_kind == OP_WRITE) |->
            op_length == {1'b0, byte_count_field} + 4'h1
            && op_address == {tag_address_high, tag_address_low};
    endproperty
    property p_info;
        info_valid |-> info_data == {48'h0, tag_block_size - 8'h01,
                                     tag_block_count - 8'h01};
    endproperty
    property p_head_off;
        !head_enable && !busy |=> !head_on;
    endproperty
    property p_head_on;
        head_enable |=> head_on;
    endproperty
    property p_hold;
        head_on && op_kind != OP_NONE |=> head_on || done;
    endproperty
    property p_reset;
        s_reset |=> done && !busy && !error && error_code == 16'h0000;
    endproperty
    a_multi: assert property (p_multi) else $error("multi bits no error");
    a_accept: assert property (p_accept) else $error("edge not taken");
    a_start: assert property (p_start) else $error("bad start pulse");
    a_abort: assert property (p_abort) else $error("long abort pulse");
    a_tag: assert property (p_tag) else $error("start without tag");
    a_len: assert property (p_len) else $error("bad length or address");
    a_info: assert property (p_info) else $error("bad info bytes");
    a_head_off: assert property (p_head_off) else $error("head stays on");
    a_head_on: assert property (p_head_on) else $error("head not on");
    a_hold: assert property (p_hold) else $error("head dropped early");
    a_reset: assert property (p_reset) else $error("reset bit ignored");
endmodule

// ### verification/rfid_head_model.sv
// Head side engine model answering start and abort pulses.
// Assumes latency is set by the bench; done is a level.
`timescale 1ns/1ns
module rfid_head_model (
    // Clock
    input  wire logic       clk,
    // Engine requests
    input  wire logic       op_start,
    input  wire logic       op_abort,
    input  wire logic [7:0] lat,
    // Engine answer
    output logic            engine_done
);
    logic [7:0] cnt = 8'h00;
    logic       run = 1'b0;
    initial engine_done = 1'b0;
    always @(posedge clk) begin
        if (op_start) begin
            engine_done <= 1'b0;
            run         <= 1'b1;
            cnt         <= lat;
        end else if (op_abort) begin
            run <= 1'b0;
        end else if (run && cnt == 8'h00) begin
            engine_done <= 1'b1;
            run         <= 1'b0;
        end else if (run) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule

// ### verification/test_rfid_command_bit_decoder.sv
// Bench: image driver notes results, monitor compares on done or error.
// Assumes checker and head model compiled first.
`timescale 1ns/1ns
module test_rfid_command_bit_decoder;
    import rfid_cmd_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        iv = 1'b0;
    logic        hen = 1'b1;
    logic        one = 1'b0;
    logic        rst = 1'b0;
    logic        tp = 1'b1;
    logic        ee = 1'b0;
    logic        tc = 1'b0;
    logic        eng;
    logic        done_d = 1'b1;
    logic        err_d = 1'b0;
    logic [4:0]  cmd = 5'h00;
    logic [2:0]  bc = 3'h0;
    logic [7:0]  ah = 8'h00;
    logic [7:0]  al = 8'h00;
    logic [7:0]  cnt8;
    logic [7:0]  sz8;
    logic [7:0]  lat = 8'h05;
    logic [81:0] note;
    logic [81:0] q[$];
    int          n_fail = 0;
    int          compares = 0;
    int          seed;
    int          k;
    logic        head_on, op_start, op_abort, busy, done, error, info_valid;
    op_t         op_kind;
    logic [15:0] op_address, error_code;
    logic [3:0]  op_length;
    logic [63:0] info_data;
    always #20 clk = ~clk;
    rfid_command_bit_decoder dut_u (.clk, .reset_n, .image_valid(iv), .head_enable(hen),
        .single_cmd_per_tag(one), .tag_identifier_cmd(cmd[CMD_TAG_IDENTIFIER_CMD]),
        .read_cmd(cmd[CMD_READ]), .write_cmd(cmd[CMD_WRITE]),
        .tag_information_cmd(cmd[CMD_TAG_INFORMATION_CMD]), .head_information_cmd(cmd[CMD_HEAD_INFO]),
        .reset_cmd(rst), .byte_count_field(bc), .tag_address_high(ah), .tag_address_low(al),
        .tag_present(tp), .tag_changed(tc), .engine_done(eng), .engine_error(ee),
        .tag_block_count(cnt8), .tag_block_size(sz8), .head_on, .op_start, .op_kind,
        .op_address, .op_length, .op_abort, .busy, .done, .error, .error_code,
        .info_valid, .info_data);
    rfid_head_model hm_u (.clk, .op_start, .op_abort, .lat, .engine_done(eng));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic img(input logic [4:0] c, input logic r);
        @(posedge clk);
        iv  <= 1'b1;
        cmd <= c;
        rst <= r;
        @(posedge clk);
        iv  <= 1'b0;
    endtask
    task automatic wt;
        int i;
        repeat (3) @(posedge clk);
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic run(input logic [4:0] c, input logic [81:0] n);
        img(5'h00, 1'b0);
        q.push_back(n);
        img(c, 1'b0);
        wt();
    endtask
    // Result monitor
    always @(negedge clk) begin
        if (reset_n && ((done && !done_d) || (error && !err_d))) begin
            if (q.size() == 0) chk(64'h1, 64'h0);
            else begin
                note = q.pop_front();
                chk({error, error_code}, note[80:64]);
                chk(info_valid, note[81]);
                if (note[81]) chk(info_data, note[63:0]);
            end
        end
        done_d <= done;
        err_d  <= error;
    end
    initial begin
        seed = 16;
        cnt8 <= 8'($random(seed));
        sz8  <= 8'($random(seed));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            bc  <= 3'($random(seed));
            ah  <= 8'($random(seed));
            al  <= 8'($random(seed));
            lat <= 8'(3 + {$random(seed)} % 40);
            run(5'h01 << k, {k == CMD_TAG_INFORMATION_CMD, 17'h0, 48'h0, sz8 - 8'h01, cnt8 - 8'h01});
        end
        ee <= 1'b1;
        run(5'h02, {2'b01, 16'h0002, 64'h0});
        ee <= 1'b0;
        img(5'h00, 1'b1);
        $display("command kinds done");
        img(5'h00, 1'b0);
        q.push_back({2'b01, 16'h0001, 64'h0});
        img(5'h06, 1'b0);
        wt();
        img(5'h00, 1'b1);
        repeat (2) @(posedge clk);
        chk({error, error_code}, 17'h0);
        $display("multi bit done");
        // no tag, then head enable dropped
        tp <= 1'b0;
        img(5'h00, 1'b0);
        q.push_back(82'h0);
        img(5'h04, 1'b0);
        repeat (30) @(posedge clk);
        chk({busy, done}, 2'b10);
        hen <= 1'b0;
        repeat (10) @(posedge clk);
        chk(head_on, 1'b1);
        tp <= 1'b1;
        wt();
        chk(head_on, 1'b0);
        hen <= 1'b1;
        $display("pending done");
        // second command on same tag locks
        one <= 1'b1;
        img(5'h00, 1'b1);
        run(5'h01, 82'h0);
        img(5'h00, 1'b0);
        img(5'h01, 1'b0);
        repeat (40) @(posedge clk);
        chk(busy, 1'b1);
        tc <= 1'b1;
        repeat (6) @(posedge clk);
        chk(busy, 1'b0);
        tc <= 1'b0;
        run(5'h01, 82'h0);
        img(5'h00, 1'b0);
        img(5'h01, 1'b0);
        repeat (10) @(posedge clk);
        chk(busy, 1'b1);
        q.push_back(82'h0);
        img(5'h01, 1'b1);
        repeat (3) @(posedge clk);
        chk(busy, 1'b0);
        one <= 1'b0;
        $display("lock done");
        lat <= 8'hC8;
        run(5'h00, 82'h0);
        img(5'h02, 1'b0);
        repeat (20) @(posedge clk);
        img(5'h02, 1'b1);
        repeat (3) @(posedge clk);
        chk(busy, 1'b0);
        repeat (5) @(posedge clk);
        chk(q.size(), 0);
        $display("abort done");
        tally_and_finish();
    end
    initial begin
        #(40 * 20000);
        n_fail++;
        tally_and_finish();
    end
endmodule
bind rfid_command_bit_decoder rfid_cmd_checker chk_u (.clk, .reset_n, .image_valid,
    .head_enable, .tag_identifier_cmd, .read_cmd, .write_cmd, .tag_information_cmd,
    .head_information_cmd, .reset_cmd, .byte_count_field, .tag_address_high,
    .tag_address_low, .tag_present, .tag_block_count, .tag_block_size, .head_on,
    .op_start, .op_kind, .op_address, .op_length, .op_abort, .busy, .done, .error,
    .error_code, .info_valid, .info_data);
